// [hw/twe_pkg.sv]
// constants, operation codes and state encoding shared by the table word engine
// assumes a 16-bit word memory with 16-bit word addresses
package twe_pkg;
  localparam int          WORD_W      = 16;
  localparam int          ADDR_W      = 16;
  localparam int          LEN_W       = 8;
  localparam logic [15:0] ACC_RESET   = 16'h0000;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [7:0]  LEN_ZERO    = 8'h00;
  localparam logic [7:0]  LEN_ONE     = 8'h01;
  localparam logic [7:0]  BYTE_LO_ONE = 8'h01;

  typedef enum logic [2:0] {
    OP_AND_COPY,
    OP_OR_COPY,
    OP_XOR_COPY,
    OP_BLOCK_SEARCH,
    OP_EXCHANGE
  } twe_op_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CP_RD,
    ST_CP_WT,
    ST_CP_WR,
    ST_SW_RDA,
    ST_SW_WTA,
    ST_SW_RDB,
    ST_SW_WTB,
    ST_SW_WRA,
    ST_SW_WRB,
    ST_FB_RDP,
    ST_FB_WTP,
    ST_FB_RDT,
    ST_FB_WTT,
    ST_FB_CMP,
    ST_DONE
  } twe_state_t;
endpackage

// [hw/twe_acc_stack.sv]
// accumulator with three stack levels beneath it
// assumes loads come from the sequencer and result writes from the engine, same clock
`timescale 1ns/1ns
module twe_acc_stack
  import twe_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              load,
  input  wire logic [WORD_W-1:0] load_value,
  input  wire logic              set,
  input  wire logic [WORD_W-1:0] set_value,
  output logic      [WORD_W-1:0] acc,
  output logic      [WORD_W-1:0] lvl1,
  output logic      [WORD_W-1:0] lvl2,
  output logic      [WORD_W-1:0] lvl3
);
  logic [WORD_W-1:0] acc_r, lvl1_r, lvl2_r, lvl3_r;
  logic [WORD_W-1:0] acc_nxt, lvl1_nxt, lvl2_nxt, lvl3_nxt;

  // ==========================================================
  // push and result write
  always_comb begin
    acc_nxt  = acc_r;
    lvl1_nxt = lvl1_r;
    lvl2_nxt = lvl2_r;
    lvl3_nxt = lvl3_r;
    if (load) begin
      lvl3_nxt = lvl2_r;
      lvl2_nxt = lvl1_r;
      lvl1_nxt = acc_r;
      acc_nxt  = load_value;
    end else if (set) begin
      // result replaces the accumulator without pushing
      acc_nxt  = set_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_r  <= ACC_RESET;
      lvl1_r <= ACC_RESET;
      lvl2_r <= ACC_RESET;
      lvl3_r <= ACC_RESET;
    end else begin
      acc_r  <= acc_nxt;
      lvl1_r <= lvl1_nxt;
      lvl2_r <= lvl2_nxt;
      lvl3_r <= lvl3_nxt;
    end
  end

  assign acc  = acc_r;
  assign lvl1 = lvl1_r;
  assign lvl2 = lvl2_r;
  assign lvl3 = lvl3_r;
endmodule // twe_acc_stack

// [hw/twe_engine.sv]
// table word engine: masked copies, block search and table exchange on word memory
// assumes a word memory that returns read data one cycle after the request cycle
`timescale 1ns/1ns
module twe_engine
  import twe_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              acc_load,
  input  wire logic [WORD_W-1:0] acc_load_value,
  input  wire logic              op_start,
  input  wire twe_op_t           op_code,
  input  wire logic [ADDR_W-1:0] op_operand,
  input  wire logic              scan_end,
  output logic                   busy,
  output logic                   op_done,
  output logic [WORD_W-1:0]      acc_value,
  output logic                   search_miss_flag,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [WORD_W-1:0]      mem_wdata,
  input  wire logic [WORD_W-1:0] mem_rdata
);
  // ==========================================================
  // helpers
  function automatic logic [ADDR_W-1:0] addr_at(input logic [ADDR_W-1:0] base, input logic [LEN_W-1:0] off);
    addr_at = base + {{(ADDR_W-LEN_W){1'b0}}, off};
  endfunction

  // true while a block of nw words starting at cand stays within end
  function automatic logic fits(input logic [ADDR_W-1:0] cand, input logic [LEN_W-1:0] nw,
                                input logic [ADDR_W-1:0] last);
    logic [ADDR_W:0] top;
    top  = {1'b0, cand} + {{(ADDR_W+1-LEN_W){1'b0}}, nw} - {{ADDR_W{1'b0}}, 1'b1};
    fits = top <= {1'b0, last};
  endfunction

  function automatic logic [WORD_W-1:0] mask_apply(input twe_op_t op, input logic [WORD_W-1:0] w,
                                                   input logic [WORD_W-1:0] m);
    unique case (op)
      OP_AND_COPY: mask_apply = w & m;
      OP_OR_COPY:  mask_apply = w | m;
      default:     mask_apply = w ^ m;
    endcase
  endfunction

  // ==========================================================
  // accumulator stack
  logic [WORD_W-1:0] lvl1, lvl2, lvl3;
  logic              acc_set;
  logic [WORD_W-1:0] acc_set_value;

  // loads are ignored while busy so parameters cannot shift under a running operation
  twe_acc_stack u_stack (
    .clk        (clk),
    .resetn     (resetn),
    .load       (acc_load & ~busy),
    .load_value (acc_load_value),
    .set        (acc_set),
    .set_value  (acc_set_value),
    .acc        (acc_value),
    .lvl1       (lvl1),
    .lvl2       (lvl2),
    .lvl3       (lvl3)
  );

  // ==========================================================
  // sequencing
  twe_state_t        state_r, state_nxt;
  twe_op_t           opc_r, opc_nxt;
  logic [LEN_W-1:0]  idx_r, idx_nxt;
  logic [LEN_W-1:0]  len_r, len_nxt;
  logic [LEN_W-1:0]  tlen_r, tlen_nxt;
  logic              odd_r, odd_nxt;
  logic [ADDR_W-1:0] a_r, a_nxt;
  logic [ADDR_W-1:0] b_r, b_nxt;
  logic [ADDR_W-1:0] end_r, end_nxt;
  logic [WORD_W-1:0] mask_r, mask_nxt;
  logic [WORD_W-1:0] tmp_r, tmp_nxt;
  logic              miss_r, miss_nxt;
  logic              req_r, req_nxt;
  logic              we_r, we_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [WORD_W-1:0] wdata_r, wdata_nxt;

  logic             last_word;
  logic             match;
  logic [LEN_W:0]   nbytes_p1;
  logic [LEN_W-1:0] nwords;

  assign last_word = (idx_r + LEN_ONE) == len_r;
  // odd byte count: only the low byte of the final word belongs to the block
  assign match     = (last_word && odd_r) ? (mem_rdata[7:0] == tmp_r[7:0]) : (mem_rdata == tmp_r);
  assign nbytes_p1 = {1'b0, lvl3[LEN_W-1:0]} + {{LEN_W{1'b0}}, 1'b1};
  assign nwords    = nbytes_p1[LEN_W:1];

  always_comb begin
    state_nxt     = state_r;
    opc_nxt       = opc_r;
    idx_nxt       = idx_r;
    len_nxt       = len_r;
    tlen_nxt      = tlen_r;
    odd_nxt       = odd_r;
    a_nxt         = a_r;
    b_nxt         = b_r;
    end_nxt       = end_r;
    mask_nxt      = mask_r;
    tmp_nxt       = tmp_r;
    miss_nxt      = miss_r;
    req_nxt       = 1'b0;
    we_nxt        = 1'b0;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    acc_set       = 1'b0;
    acc_set_value = b_r;
    if (scan_end) miss_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (op_start) begin
          opc_nxt = op_code;
          idx_nxt = LEN_ZERO;
          case (op_code)
            OP_AND_COPY, OP_OR_COPY, OP_XOR_COPY: begin
              len_nxt   = lvl2[LEN_W-1:0];
              a_nxt     = lvl1;
              mask_nxt  = acc_value;
              b_nxt     = op_operand;
              state_nxt = (lvl2[LEN_W-1:0] == LEN_ZERO) ? ST_DONE : ST_CP_RD;
            end
            OP_EXCHANGE: begin
              len_nxt   = lvl1[LEN_W-1:0];
              a_nxt     = acc_value;
              b_nxt     = op_operand;
              state_nxt = (lvl1[LEN_W-1:0] == LEN_ZERO) ? ST_DONE : ST_SW_RDA;
            end
            OP_BLOCK_SEARCH: begin
              len_nxt   = nwords;
              odd_nxt   = lvl3[0];
              tlen_nxt  = lvl2[LEN_W-1:0];
              end_nxt   = lvl1;
              b_nxt     = acc_value;
              a_nxt     = op_operand;
              miss_nxt  = 1'b0;
              if (lvl3[LEN_W-1:0] == LEN_ZERO || lvl2[LEN_W-1:0] == LEN_ZERO ||
                  !fits(acc_value, nwords, lvl1)) begin
                miss_nxt  = 1'b1;
                state_nxt = ST_DONE;
              end else begin
                state_nxt = ST_FB_RDP;
              end
            end
            default: state_nxt = ST_DONE; // unknown code completes with no effect
          endcase
        end
      end
      ST_CP_RD: begin
        req_nxt   = 1'b1;
        addr_nxt  = addr_at(a_r, idx_r);
        state_nxt = ST_CP_WT;
      end
      ST_CP_WT: state_nxt = ST_CP_WR;
      ST_CP_WR: begin
        req_nxt   = 1'b1;
        we_nxt    = 1'b1;
        addr_nxt  = addr_at(b_r, idx_r);
        wdata_nxt = mask_apply(opc_r, mem_rdata, mask_r);
        idx_nxt   = idx_r + LEN_ONE;
        state_nxt = last_word ? ST_DONE : ST_CP_RD;
      end
      ST_SW_RDA: begin
        req_nxt   = 1'b1;
        addr_nxt  = addr_at(a_r, idx_r);
        state_nxt = ST_SW_WTA;
      end
      ST_SW_WTA: state_nxt = ST_SW_RDB;
      ST_SW_RDB: begin
        tmp_nxt   = mem_rdata;
        req_nxt   = 1'b1;
        addr_nxt  = addr_at(b_r, idx_r);
        state_nxt = ST_SW_WTB;
      end
      ST_SW_WTB: state_nxt = ST_SW_WRA;
      ST_SW_WRA: begin
        req_nxt   = 1'b1;
        we_nxt    = 1'b1;
        addr_nxt  = addr_at(a_r, idx_r);
        wdata_nxt = mem_rdata;
        state_nxt = ST_SW_WRB;
      end
      ST_SW_WRB: begin
        req_nxt   = 1'b1;
        we_nxt    = 1'b1;
        addr_nxt  = addr_at(b_r, idx_r);
        wdata_nxt = tmp_r;
        idx_nxt   = idx_r + LEN_ONE;
        state_nxt = last_word ? ST_DONE : ST_SW_RDA;
      end
      ST_FB_RDP: begin
        req_nxt   = 1'b1;
        addr_nxt  = addr_at(a_r, idx_r);
        state_nxt = ST_FB_WTP;
      end
      ST_FB_WTP: state_nxt = ST_FB_RDT;
      ST_FB_RDT: begin
        tmp_nxt   = mem_rdata;
        req_nxt   = 1'b1;
        addr_nxt  = addr_at(b_r, idx_r);
        state_nxt = ST_FB_WTT;
      end
      ST_FB_WTT: state_nxt = ST_FB_CMP;
      ST_FB_CMP: begin
        if (match && last_word) begin
          acc_set   = 1'b1;
          state_nxt = ST_DONE;
        end else if (match) begin
          idx_nxt   = idx_r + LEN_ONE;
          state_nxt = ST_FB_RDP;
        end else begin
          // candidates sit only on table boundaries of the run
          b_nxt   = addr_at(b_r, tlen_r);
          idx_nxt = LEN_ZERO;
          if (!fits(addr_at(b_r, tlen_r), len_r, end_r) || addr_at(b_r, tlen_r) < b_r) begin
            miss_nxt  = 1'b1;
            state_nxt = ST_DONE;
          end else begin
            state_nxt = ST_FB_RDP;
          end
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      opc_r   <= OP_AND_COPY;
      idx_r   <= LEN_ZERO;
      len_r   <= LEN_ZERO;
      tlen_r  <= LEN_ZERO;
      odd_r   <= 1'b0;
      a_r     <= WORD_ZERO;
      b_r     <= WORD_ZERO;
      end_r   <= WORD_ZERO;
      mask_r  <= WORD_ZERO;
      tmp_r   <= WORD_ZERO;
      miss_r  <= 1'b0;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= WORD_ZERO;
      wdata_r <= WORD_ZERO;
    end else begin
      state_r <= state_nxt;
      opc_r   <= opc_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      tlen_r  <= tlen_nxt;
      odd_r   <= odd_nxt;
      a_r     <= a_nxt;
      b_r     <= b_nxt;
      end_r   <= end_nxt;
      mask_r  <= mask_nxt;
      tmp_r   <= tmp_nxt;
      miss_r  <= miss_nxt;
      req_r   <= req_nxt;
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign busy             = state_r != ST_IDLE;
  assign op_done          = state_r == ST_DONE;
  assign search_miss_flag = miss_r;
  assign mem_req          = req_r;
  assign mem_we           = we_r;
  assign mem_addr         = addr_r;
  assign mem_wdata        = wdata_r;
endmodule // twe_engine

// [test/twe_engine_props.sv]
// checker for the table word engine, sees only its ports
// assumes bind from the bench top; one clock domain
`timescale 1ns/1ns
module twe_engine_props
  import twe_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              acc_load,
  input wire logic [WORD_W-1:0] acc_load_value,
  input wire logic              op_start,
  input wire twe_op_t           op_code,
  input wire logic [ADDR_W-1:0] op_operand,
  input wire logic              scan_end,
  input wire logic              busy,
  input wire logic              op_done,
  input wire logic [WORD_W-1:0] acc_value,
  input wire logic              search_miss_flag,
  input wire logic              mem_req,
  input wire logic              mem_we,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [WORD_W-1:0] mem_wdata,
  input wire logic [WORD_W-1:0] mem_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========
  // operation framing
  a_done_in_busy: assert property (op_done |-> busy) else $error("done outside busy");
  a_done_one_cycle: assert property (op_done |=> !op_done) else $error("done longer than one cycle");
  a_start_goes_busy: assert property (op_start && !busy && op_code <= OP_EXCHANGE |=> busy)
    else $error("issue not taken");
  a_idle_no_access: assert property (!busy |-> !mem_req) else $error("memory access while idle");
  // ==========
  // accumulator and flag, operation covers
  a_load_pushes_acc: assert property (acc_load && !busy && !op_start |=> acc_value == $past(acc_load_value))
    else $error("load not in accumulator");
  a_acc_stable_busy: assert property ((busy && !op_done) ##1 (busy && !op_done) |-> $stable(acc_value))
    else $error("accumulator moved mid operation");
  a_scan_end_clears: assert property (scan_end && !busy && !op_start |=> !search_miss_flag)
    else $error("miss flag kept past scan end");
  a_miss_holds: assert property (search_miss_flag && !scan_end && !(op_start && !busy) |=> search_miss_flag)
    else $error("miss flag dropped early");
  c_copy: cover property (op_start && !busy && op_code == OP_AND_COPY);
  c_swap: cover property (op_start && !busy && op_code == OP_EXCHANGE);
  c_miss: cover property ($rose(search_miss_flag));
endmodule // twe_engine_props

// [test/twe_mem_model.sv]
// word memory model on the far side of the engine
// assumes one request per cycle; read data valid the cycle after the request
`timescale 1ns/1ns
module twe_mem_model
  import twe_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [WORD_W-1:0] mem_wdata,
  output logic      [WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] mem [0:255];
  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 256; i++) mem[i] = 16'h0000;
  end
  // idle cycles show inverted data so a late sample is caught
  always @(posedge clk) begin
    if (mem_req && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_req && !mem_we) mem_rdata <= mem[mem_addr[7:0]];
    else mem_rdata <= ~mem_rdata;
  end
endmodule // twe_mem_model

// [test/twe_engine_tb.sv]
// self-checking bench for the table word engine
// assumes the memory model as far side and the checker bound below
`timescale 1ns/1ns
module twe_engine_tb;
  import twe_pkg::*;
  logic              clk;
  logic              resetn;
  logic              acc_load;
  logic [WORD_W-1:0] acc_load_value;
  logic              op_start;
  twe_op_t           op_code;
  logic [ADDR_W-1:0] op_operand;
  logic              scan_end;
  logic              busy;
  logic              op_done;
  logic [WORD_W-1:0] acc_value;
  logic              search_miss_flag;
  logic              mem_req;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_rdata;
  int                error_cnt;
  int                comparisons;
  twe_engine dut (.clk(clk), .resetn(resetn), .acc_load(acc_load), .acc_load_value(acc_load_value),
    .op_start(op_start), .op_code(op_code), .op_operand(op_operand), .scan_end(scan_end), .busy(busy),
    .op_done(op_done), .acc_value(acc_value), .search_miss_flag(search_miss_flag), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  twe_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // ==========
  // helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic load(input logic [15:0] v);
    @(negedge clk) acc_load = 1'b1;
    acc_load_value = v;
    @(negedge clk) acc_load = 1'b0;
  endtask
  task automatic issue(input twe_op_t op, input logic [15:0] opnd);
    int n;
    n = 0;
    @(negedge clk) op_start = 1'b1;
    op_code = op;
    op_operand = opnd;
    @(negedge clk) op_start = 1'b0;
    while (op_done !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      error_cnt++;
      $display("mismatch op_done expected 1 seen 0");
    end
    @(negedge clk);
  endtask
  // ==========
  // scenarios
  task automatic t_copies();
    logic [15:0] m [3];
    logic [15:0] e;
    m = '{16'h6666, 16'h8888, 16'h3333};
    u_mem.mem[16] = 16'h1234;
    u_mem.mem[17] = 16'hF0F1;
    for (int i = 0; i < 3; i++) begin
      load(16'h0002);
      load(16'h0010);
      load(m[i]);
      issue(twe_op_t'(i), 16'h0020 + 16'(i * 4));
      for (int w = 0; w < 2; w++) begin
        e = (i == 0) ? (u_mem.mem[16 + w] & m[i]) : (i == 1) ? (u_mem.mem[16 + w] | m[i])
          : (u_mem.mem[16 + w] ^ m[i]);
        chk("copy word", e, u_mem.mem[32 + i * 4 + w]);
      end
      chk("copy bound", 16'h0000, u_mem.mem[34 + i * 4]);
    end
  endtask
  task automatic t_zero_len();
    load(16'h0000);
    load(16'h0010);
    load(16'hFFFF);
    issue(OP_OR_COPY, 16'h002C);
    chk("zero length", 16'h0000, u_mem.mem[44]);
    // undefined codes must finish without touching memory or the accumulator
    load(16'h0001);
    load(16'h0010);
    load(16'hFFFF);
    issue(twe_op_t'(3'h5), 16'h002C);
    chk("undefined code mem", 16'h0000, u_mem.mem[44]);
    chk("undefined code acc", 16'hFFFF, acc_value);
  endtask
  task automatic t_swap();
    u_mem.mem[48] = 16'hA5C3;
    u_mem.mem[49] = 16'h0FF0;
    u_mem.mem[64] = 16'h5A3C;
    u_mem.mem[65] = 16'hFFFF;
    load(16'h0002);
    load(16'h0030);
    issue(OP_EXCHANGE, 16'h0040);
    chk("swap a0", 16'h5A3C, u_mem.mem[48]);
    chk("swap a1", 16'hFFFF, u_mem.mem[49]);
    chk("swap b0", 16'hA5C3, u_mem.mem[64]);
    chk("swap b1", 16'h0FF0, u_mem.mem[65]);
  endtask
  task automatic t_search();
    u_mem.mem[96] = 16'hA1B2;
    u_mem.mem[97] = 16'hC3D4;
    u_mem.mem[84] = 16'hA1B2;
    u_mem.mem[85] = 16'hC3D4;
    u_mem.mem[98] = 16'h7777;
    load(16'h0004);
    load(16'h0004);
    load(16'h005B);
    load(16'h0050);
    issue(OP_BLOCK_SEARCH, 16'h0060);
    chk("found addr", 16'h0054, acc_value);
    chk("found miss", 16'h0000, {15'h0000, search_miss_flag});
    load(16'h0002);
    load(16'h0004);
    load(16'h005B);
    load(16'h0050);
    issue(OP_BLOCK_SEARCH, 16'h0062);
    chk("miss flag", 16'h0001, {15'h0000, search_miss_flag});
    @(negedge clk) scan_end = 1'b1;
    @(negedge clk) scan_end = 1'b0;
    chk("miss cleared", 16'h0000, {15'h0000, search_miss_flag});
  endtask
  // ==========
  // run control
  task automatic finish_test();
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    // long enough for every scenario several times over
    #200000;
    error_cnt++;
    finish_test();
  end
  initial begin
    error_cnt = 0;
    comparisons = 0;
    resetn = 1'b0;
    acc_load = 1'b0;
    acc_load_value = 16'h0000;
    op_start = 1'b0;
    op_code = OP_AND_COPY;
    op_operand = 16'h0000;
    scan_end = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_copies();
    t_zero_len();
    t_swap();
    t_search();
    finish_test();
  end
endmodule // twe_engine_tb
bind twe_engine twe_engine_props u_props (.clk(clk), .resetn(resetn), .acc_load(acc_load),
  .acc_load_value(acc_load_value), .op_start(op_start), .op_code(op_code), .op_operand(op_operand),
  .scan_end(scan_end), .busy(busy), .op_done(op_done), .acc_value(acc_value),
  .search_miss_flag(search_miss_flag), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
